//--- include/adc_status_pkg.sv
// Purpose: shared constants and carriers for the converter status block
// Assumes: register port in the core clock domain, 24-bit register words
// Notes:   channel map bytes hold ch5..ch3 (high) and ch2..ch0 (low)
`default_nettype none
package adc_status_pkg;
  localparam int NUM_CH = 6;

  // register addresses on the register port
  localparam logic [4:0] ADDR_STAT   = 5'h00;
  localparam logic [4:0] ADDR_CTRL1  = 5'h01;
  localparam logic [4:0] ADDR_CHMAPH = 5'h06;
  localparam logic [4:0] ADDR_CHMAPL = 5'h07;
  localparam logic [4:0] ADDR_SEQ    = 5'h08;
  localparam logic [4:0] ADDR_DATA0  = 5'h0e;
  localparam logic [4:0] ADDR_DATA5  = 5'h13;

  // status word field positions
  localparam int STAT_IN_RESET_BIT = 22;
  localparam int STAT_READY_LSB    = 16;
  localparam int STAT_SCAN_CONFIG_ERROR_BIT  = 15;
  localparam int STAT_REFERENCE_PRESENT_BIT   = 14;
  localparam int STAT_CHANNEL_ORDER_ERROR_BIT   = 13;
  localparam int STAT_PINERR_BIT   = 12;
  localparam int STAT_CFGERR_BIT   = 11;

  // control field positions
  localparam int CTRL1_CAL_LSB    = 6;
  localparam int CTRL1_SINGLE_CYCLE_SELECT_BIT = 1;
  localparam int SEQ_MODE_LSB     = 3;

  // reset values
  localparam logic [23:0] STAT_RESET  = 24'h004000;
  localparam logic [7:0]  CTRL1_RESET = 8'h00;
  localparam logic [7:0]  SEQ_RESET   = 8'h00;
  localparam logic [23:0] CHMAP_RESET = 24'h000000;

  // encodings
  localparam logic [2:0] ORD_BAD_LOW  = 3'h0;
  localparam logic [2:0] ORD_BAD_HIGH = 3'h7;
  localparam logic [1:0] CAL_RESERVED = 2'h3;
  localparam logic [1:0] MODE_SCAN_A  = 2'h2;
  localparam logic [1:0] MODE_SCAN_B  = 2'h3;
  localparam logic [1:0] PWR_CONVERT  = 2'h0;
  localparam logic [1:0] PWR_SLEEP    = 2'h1;
  localparam logic [1:0] PWR_STANDBY  = 2'h2;

  // one channel map byte, bits 6..0
  typedef struct packed {
    logic [1:0] pin_sel;
    logic [2:0] order;
    logic       scan_en;
    logic       pin_en;
  } chan_cfg_t;

  typedef struct packed {
    logic scan;
    logic order;
    logic pin_map;
    logic general;
  } cfg_err_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        rd_done;
    logic [4:0]  addr;
    logic [23:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

//--- design/chmap_checker.sv
// Purpose: combinational check of the scan channel map
// Assumes: six channels, order codes 001..110 valid
// Notes:   pairwise compares, no state
`default_nettype none
module chmap_checker (
  input  wire adc_status_pkg::chan_cfg_t [5:0] cfg,
  input  wire logic                            scan_mode,
  output logic                                 order_err,
  output logic                                 scan_err,
  output logic                                 pin_err
);
  logic [5:0]      en_vec;
  logic [5:0]      bad_code;
  logic [5:0]      gap;
  logic [5:0][5:0] ord_clash;
  logic [5:0][5:0] pin_clash;
  logic [2:0]      en_count;

  assign en_count = 3'($countones(en_vec));

  for (genvar i = 0; i < adc_status_pkg::NUM_CH; i++) begin : g_ch
    assign en_vec[i]   = cfg[i].scan_en;
    assign bad_code[i] = cfg[i].scan_en &&
                         (cfg[i].order == adc_status_pkg::ORD_BAD_LOW ||
                          cfg[i].order == adc_status_pkg::ORD_BAD_HIGH);
    assign gap[i] = cfg[i].scan_en && (cfg[i].order > en_count);
    for (genvar j = 0; j < adc_status_pkg::NUM_CH; j++) begin : g_pair
      if (j > i) begin : g_up
        assign ord_clash[i][j] = cfg[i].scan_en && cfg[j].scan_en &&
                                 (cfg[i].order == cfg[j].order);
        assign pin_clash[i][j] = cfg[i].pin_en && cfg[j].pin_en &&
                                 (cfg[i].pin_sel == cfg[j].pin_sel);
      end else begin : g_low
        assign ord_clash[i][j] = 1'b0;
        assign pin_clash[i][j] = 1'b0;
      end
    end
  end

  assign order_err = (|ord_clash) || (|bad_code) || (|gap);
  assign scan_err  = scan_mode && ((en_vec == 6'h00) || (|bad_code));
  assign pin_err   = |pin_clash;
endmodule
`default_nettype wire

//--- design/ready_flags.sv
// Purpose: per-channel result ready flags
// Assumes: result and read strobes are single-cycle pulses
// Notes:   a new result wins over a clear in the same cycle
`default_nettype none
module ready_flags (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       scan_mode,
  input  wire logic       result_valid,
  input  wire logic [2:0] result_ch,
  input  wire logic       scan_start,
  input  wire logic       read_done,
  input  wire logic [2:0] read_ch,
  output logic      [5:0] ready_q
);
  for (genvar i = 0; i < adc_status_pkg::NUM_CH; i++) begin : g_flag
    logic set_now;
    logic clr_now;
    assign set_now = scan_mode && result_valid && (result_ch == 3'(i));
    assign clr_now = scan_start || (read_done && (read_ch == 3'(i)));
    always_ff @(posedge core_clk) begin
      if (reset) begin
        ready_q[i] <= 1'b0;
      end else if (set_now) begin
        ready_q[i] <= 1'b1;
      end else if (clr_now) begin
        ready_q[i] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/adc_status_config_checker.sv
// Purpose: status flags and scan configuration checks of the converter
// Assumes: register port and datapath strobes share core_clk
// Notes:   data, calibration and rate fields live elsewhere and read zero
`default_nettype none
module adc_status_config_checker (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire adc_status_pkg::reg_req_t reg_req,
  output logic                   [23:0] reg_rdata,
  output logic                          reg_rvalid,
  input  wire logic                     reset_busy,
  input  wire logic              [1:0]  power_state,
  input  wire logic                     ref_level_ok,
  input  wire logic                     result_valid,
  input  wire logic              [2:0]  result_ch,
  input  wire logic                     scan_start,
  input  wire logic                     conv_cmd,
  input  wire logic                     conv_done,
  output logic                          conv_start,
  output logic                          conv_abort,
  output logic                          standby_force,
  output logic                          converting,
  output logic                   [23:0] device_condition_flags
);
  typedef enum logic [0:0] {
    st_standby,
    st_converting
  } conv_state_t;

  conv_state_t state_q;
  conv_state_t state_d;

  logic [7:0]  ctrl1_q;
  logic [7:0]  seq_q;
  logic [23:0] chmap_high_q;
  logic [23:0] chmap_low_q;
  logic [23:0] stat_q;
  logic [23:0] stat_d;
  logic [23:0] rdata_d;
  logic        conv_start_q;
  logic        conv_abort_q;

  adc_status_pkg::chan_cfg_t [5:0] chan_cfg;
  adc_status_pkg::cfg_err_t        cfg_err;

  logic [1:0] seq_mode;
  logic [1:0] cal_select;
  logic       single_cycle_select;
  logic       scan_mode;
  logic       any_cfg_err;
  logic       data_read_done;
  logic [2:0] data_read_ch;
  logic [5:0] ready;
  logic       reference_present;
  logic       in_reset_flag;

  // ------------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------------
  assign seq_mode = seq_q[adc_status_pkg::SEQ_MODE_LSB +: 2];
  assign cal_select = ctrl1_q[adc_status_pkg::CTRL1_CAL_LSB +: 2];
  assign single_cycle_select = ctrl1_q[adc_status_pkg::CTRL1_SINGLE_CYCLE_SELECT_BIT];
  assign scan_mode = (seq_mode == adc_status_pkg::MODE_SCAN_A) ||
                     (seq_mode == adc_status_pkg::MODE_SCAN_B);

  // channel map low holds ch2..ch0, high holds ch5..ch3, one byte each
  assign chan_cfg[0] = chmap_low_q[6:0];
  assign chan_cfg[1] = chmap_low_q[14:8];
  assign chan_cfg[2] = chmap_low_q[22:16];
  assign chan_cfg[3] = chmap_high_q[6:0];
  assign chan_cfg[4] = chmap_high_q[14:8];
  assign chan_cfg[5] = chmap_high_q[22:16];

  // ------------------------------------------------------------------
  // host writes to control registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl1_q <= adc_status_pkg::CTRL1_RESET;
    end else if (reg_req.wr && reg_req.addr == adc_status_pkg::ADDR_CTRL1) begin
      ctrl1_q <= reg_req.wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seq_q <= adc_status_pkg::SEQ_RESET;
    end else if (reg_req.wr && reg_req.addr == adc_status_pkg::ADDR_SEQ) begin
      seq_q <= reg_req.wdata[7:0];
    end
  end

  // bit 7 of each channel byte is reserved and kept at zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      chmap_high_q <= adc_status_pkg::CHMAP_RESET;
    end else if (reg_req.wr &&
                 reg_req.addr == adc_status_pkg::ADDR_CHMAPH) begin
      chmap_high_q <= reg_req.wdata & 24'h7f7f7f;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      chmap_low_q <= adc_status_pkg::CHMAP_RESET;
    end else if (reg_req.wr &&
                 reg_req.addr == adc_status_pkg::ADDR_CHMAPL) begin
      chmap_low_q <= reg_req.wdata & 24'h7f7f7f;
    end
  end

  // ------------------------------------------------------------------
  // configuration checks; all purely combinational so a corrected
  // setting drops its flag in the very next status update
  // ------------------------------------------------------------------
  chmap_checker u_chmap_checker (
    .cfg       (chan_cfg),
    .scan_mode (scan_mode),
    .order_err (cfg_err.order),
    .scan_err  (cfg_err.scan),
    .pin_err   (cfg_err.pin_map)
  );

  assign cfg_err.general =
    (cal_select == adc_status_pkg::CAL_RESERVED) ||
    (scan_mode && !single_cycle_select);

  assign any_cfg_err = cfg_err.scan || cfg_err.order ||
                       cfg_err.pin_map || cfg_err.general;

  // ------------------------------------------------------------------
  // ready flags and complete data register reads
  // ------------------------------------------------------------------
  // the serial port reports rd_done only after the last byte went out,
  // so an aborted read never reaches the flags
  assign data_read_done = reg_req.rd_done &&
                          (reg_req.addr >= adc_status_pkg::ADDR_DATA0) &&
                          (reg_req.addr <= adc_status_pkg::ADDR_DATA5);
  assign data_read_ch = 3'(reg_req.addr - adc_status_pkg::ADDR_DATA0);

  ready_flags u_ready_flags (
    .core_clk     (core_clk),
    .reset        (reset),
    .scan_mode    (scan_mode),
    .result_valid (result_valid),
    .result_ch    (result_ch),
    .scan_start   (scan_start),
    .read_done    (data_read_done),
    .read_ch      (data_read_ch),
    .ready_q      (ready)
  );

  // ------------------------------------------------------------------
  // reference and reset indications
  // ------------------------------------------------------------------
  // reference comparator
  assign reference_present = ref_level_ok &&
                             (power_state != adc_status_pkg::PWR_SLEEP) &&
                             (power_state != adc_status_pkg::PWR_STANDBY) &&
                             !standby_force;

  assign in_reset_flag = reset_busy;

  // ------------------------------------------------------------------
  // conversion gate: errors hold standby, reference never does
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_standby: begin
        if (conv_cmd && !any_cfg_err) begin
          state_d = st_converting;
        end
      end
      st_converting: begin
        if (any_cfg_err || conv_done) begin
          state_d = st_standby;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= st_standby;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_start_q <= 1'b0;
      conv_abort_q <= 1'b0;
    end else begin
      conv_start_q <= conv_cmd && !any_cfg_err &&
                      (state_q == st_standby);
      conv_abort_q <= conv_cmd && any_cfg_err;
    end
  end

  assign conv_start    = conv_start_q;
  assign conv_abort    = conv_abort_q;
  assign converting    = (state_q == st_converting);
  assign standby_force = any_cfg_err;

  // ------------------------------------------------------------------
  // status word
  // ------------------------------------------------------------------
  always_comb begin
    stat_d = 24'h000000;
    stat_d[adc_status_pkg::STAT_IN_RESET_BIT] = in_reset_flag;
    stat_d[adc_status_pkg::STAT_READY_LSB +: 6] = ready;
    stat_d[adc_status_pkg::STAT_SCAN_CONFIG_ERROR_BIT] = cfg_err.scan;
    stat_d[adc_status_pkg::STAT_REFERENCE_PRESENT_BIT] = reference_present;
    stat_d[adc_status_pkg::STAT_CHANNEL_ORDER_ERROR_BIT] = cfg_err.order;
    stat_d[adc_status_pkg::STAT_PINERR_BIT] = cfg_err.pin_map;
    stat_d[adc_status_pkg::STAT_CFGERR_BIT] = cfg_err.general;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_q <= adc_status_pkg::STAT_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign device_condition_flags = stat_q;

  // ------------------------------------------------------------------
  // register read-back; data and calibration words are served by the
  // datapath, so this block answers zero for them and for holes
  // ------------------------------------------------------------------
  always_comb begin
    rdata_d = 24'h000000;
    unique case (reg_req.addr)
      adc_status_pkg::ADDR_STAT: begin
        rdata_d = stat_q;
      end
      adc_status_pkg::ADDR_CTRL1: begin
        rdata_d = {16'h0000, ctrl1_q};
      end
      adc_status_pkg::ADDR_CHMAPH: begin
        rdata_d = chmap_high_q;
      end
      adc_status_pkg::ADDR_CHMAPL: begin
        rdata_d = chmap_low_q;
      end
      adc_status_pkg::ADDR_SEQ: begin
        rdata_d = {16'h0000, seq_q};
      end
      default: begin
        rdata_d = 24'h000000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 24'h000000;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
    end
  end
endmodule
`default_nettype wire

//--- tb/status_sva.sv
// Purpose: port checks of the status block
// Assumes: one clock, synchronous reset
// Notes:   the status word lags its causes by one cycle, the ready flags by two
`default_nettype none
module status_sva (
  input wire logic                     core_clk,
  input wire logic                     reset,
  input wire adc_status_pkg::reg_req_t reg_req,
  input wire logic                     reset_busy,
  input wire logic               [1:0] power_state,
  input wire logic                     ref_level_ok,
  input wire logic                     result_valid,
  input wire logic                     scan_start,
  input wire logic                     conv_cmd,
  input wire logic                     conv_start,
  input wire logic                     conv_abort,
  input wire logic                     standby_force,
  input wire logic                     converting,
  input wire logic              [23:0] device_condition_flags
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic [23:0] st = device_condition_flags;

  a_in_reset_flag: assert property (
    !$past(reset) |-> st[22] == $past(reset_busy))
    else $error("in-reset flag wrong");
  a_ref_low_power: assert property (
    power_state != adc_status_pkg::PWR_CONVERT |=> !st[14])
    else $error("reference flag outside conversion");
  a_ref_missing: assert property (
    !ref_level_ok |=> !st[14])
    else $error("reference flag without reference");
  a_abort_on_error: assert property (
    conv_cmd && standby_force |=> conv_abort && !conv_start)
    else $error("command not aborted");
  a_start_when_clean: assert property (
    conv_cmd && !standby_force && !converting |=> conv_start && !conv_abort)
    else $error("clean command not started");
  a_error_has_cause: assert property (
    !$past(reset) && !$past(standby_force) |-> {st[15], st[13:11]} == 4'h0)
    else $error("error flag without cause");
  a_ready_scan_clear: assert property (
    scan_start && !result_valid |-> ##2 st[21:16] == 6'h00)
    else $error("ready flags survive scan start");
  a_ready_held: assert property (
    !scan_start && !reg_req.rd_done |=>
      ##1 (st[21:16] & $past(st[21:16])) == $past(st[21:16]))
    else $error("ready flag dropped without read");
endmodule

bind adc_status_config_checker status_sva chk_u (
  .core_clk, .reset, .reg_req, .reset_busy, .power_state, .ref_level_ok,
  .result_valid, .scan_start, .conv_cmd, .conv_start, .conv_abort,
  .standby_force, .converting, .device_condition_flags);
`default_nettype wire

//--- tb/host_model.sv
// Purpose: serial host controller on the register port
// Assumes: requests launched at the falling edge, one cycle each
// Notes:   idle address and data show inverted junk, not the last value
`default_nettype none
module host_model (
  input  wire logic                     core_clk,
  input  wire logic              [23:0] reg_rdata,
  input  wire logic                     reg_rvalid,
  output var  adc_status_pkg::reg_req_t reg_req
);
  initial reg_req = '0;

  task automatic put(input logic [2:0] k, input logic [4:0] a,
                     input logic [23:0] v);
    @(negedge core_clk);
    reg_req = {k, a, v};
    @(negedge core_clk);
    reg_req = {3'h0, ~a, ~v};
  endtask

  task automatic wr(input logic [4:0] a, input logic [23:0] v);
    put(3'h2, a, v);
  endtask

  task automatic rd(input logic [4:0] a, output logic [23:0] v);
    put(3'h4, a, 24'h000000);
    v = reg_rvalid ? reg_rdata : 'x;
  endtask

  // rd_done only after the whole word
  task automatic read_whole(input logic [4:0] a);
    logic [23:0] v;
    rd(a, v);
    put(3'h1, a, 24'h000000);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_adc_status_config_checker.sv
// Purpose: self-checking bench of the status block
// Assumes: inputs change at the falling edge
// Notes:   expected errors are worked out from the channel map
`default_nettype none
module tb_adc_status_config_checker;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, reset = 1'h1, reset_busy = 1'h0;
  logic ref_level_ok = 1'h1, result_valid = 1'h0, scan_start = 1'h0;
  logic conv_cmd = 1'h0, conv_done = 1'h0, reg_rvalid, conv_start;
  logic conv_abort, standby_force, converting, scyc;
  logic [1:0] power_state = 2'h0, mode, cal;
  logic [2:0] result_ch = 3'h0;
  logic [23:0] reg_rdata, device_condition_flags, st, sv;
  adc_status_pkg::reg_req_t reg_req;
  adc_status_pkg::chan_cfg_t [5:0] cfg;
  int miscompares = 0, comparisons = 0;

  adc_status_config_checker dut_u (
    .core_clk, .reset, .reg_req, .reg_rdata, .reg_rvalid, .reset_busy,
    .power_state, .ref_level_ok, .result_valid, .result_ch, .scan_start,
    .conv_cmd, .conv_done, .conv_start, .conv_abort, .standby_force,
    .converting, .device_condition_flags);
  host_model host_u (.core_clk, .reg_rdata, .reg_rvalid, .reg_req);

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(string n, logic [23:0] e, logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic status();
    repeat (2) @(negedge core_clk);
    host_u.rd(adc_status_pkg::ADDR_STAT, st);
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge core_clk);
    s = 1'h0;
  endtask

  task automatic apply();
    host_u.wr(adc_status_pkg::ADDR_CTRL1, {16'h0000, cal, 4'h0, scyc, 1'h0});
    host_u.wr(adc_status_pkg::ADDR_SEQ, {19'h00000, mode, 3'h0});
    host_u.wr(adc_status_pkg::ADDR_CHMAPH,
              {1'h0, cfg[5], 1'h0, cfg[4], 1'h0, cfg[3]});
    host_u.wr(adc_status_pkg::ADDR_CHMAPL,
              {1'h0, cfg[2], 1'h0, cfg[1], 1'h0, cfg[0]});
  endtask

  task automatic base();
    cfg = '0;
    mode = 2'h3;
    cal = 2'h0;
    scyc = 1'h1;
    for (int i = 0; i < 4; i++) begin
      cfg[i] = '{2'(i), 3'(i + 1), 1'h1, 1'h1};
    end
  endtask

  // order codes must run 1..n without repeats, scan needs a channel
  function automatic logic [3:0] exp_err();
    int n;
    logic z, o, p;
    n = 0;
    z = 1'h0;
    o = 1'h0;
    p = 1'h0;
    for (int i = 0; i < 6; i++) begin
      n += cfg[i].scan_en;
    end
    for (int i = 0; i < 6; i++) begin
      if (cfg[i].scan_en && cfg[i].order inside {3'h0, 3'h7}) z = 1'h1;
      if (cfg[i].scan_en && cfg[i].order > n) o = 1'h1;
      for (int j = i + 1; j < 6; j++) begin
        if (cfg[i].scan_en && cfg[j].scan_en && cfg[i].order == cfg[j].order)
          o = 1'h1;
        if (cfg[i].pin_en && cfg[j].pin_en && cfg[i].pin_sel == cfg[j].pin_sel)
          p = 1'h1;
      end
    end
    return {mode[1] && (n == 0 || z), o || z, p,
            cal == adc_status_pkg::CAL_RESERVED || (mode[1] && !scyc)};
  endfunction

  // missing reference is drawn at random: it must not sway the gate
  task automatic cfg_test();
    logic [3:0] e;
    e = exp_err();
    ref_level_ok = 1'($urandom());
    apply();
    status();
    check("errors", 24'(e), 24'({st[15], st[13:11]}));
    check("standby", 24'(|e), 24'(standby_force));
    pulse(conv_cmd);
    check("abort", 24'(|e), 24'(conv_abort));
    check("start", 24'(~|e), 24'(conv_start));
    check("converting", 24'(~|e), 24'(converting));
    pulse(conv_done);
  endtask

  initial begin
    void'($urandom(32'h10288a85));
    repeat (5) @(negedge core_clk);
    check("reset value", adc_status_pkg::STAT_RESET, device_condition_flags);
    reset = 1'h0;
    for (int k = 0; k < 10; k++) begin
      base();
      case (k)
        1: cfg[3].order = 3'h5;
        2: cfg[3].order = 3'h3;
        3: cfg[0].order = 3'h7;
        4: cfg[0].order = 3'h0;
        5: cfg = '0;
        6: cfg[1].pin_sel = 2'h0;
        7: cal = adc_status_pkg::CAL_RESERVED;
        8: scyc = 1'h0;
        default: ;
      endcase
      cfg_test();
    end
    for (int k = 0; k < 40; k++) begin
      cfg = 42'({$urandom(), $urandom()});
      {mode, cal, scyc} = 5'($urandom());
      cfg_test();
    end
    $display("test config done");
    base();
    apply();
    pulse(scan_start);
    result_valid = 1'h1;
    for (int c = 0; c < 6; c++) begin
      result_ch = 3'(c);
      @(negedge core_clk);
    end
    result_valid = 1'h0;
    status();
    check("ready all", 24'h00003f, 24'(st[21:16]));
    host_u.rd(5'(adc_status_pkg::ADDR_DATA0 + 5'h02), sv);
    status();
    check("partial read", 24'h00003f, 24'(st[21:16]));
    host_u.read_whole(5'(adc_status_pkg::ADDR_DATA0 + 5'h02));
    status();
    check("whole read", 24'h00003b, 24'(st[21:16]));
    pulse(scan_start);
    status();
    check("scan start", 24'h000000, 24'(st[21:16]));
    mode = 2'h0;
    apply();
    result_ch = 3'h1;
    pulse(result_valid);
    status();
    check("ready mode 0", 24'h000000, 24'(st[21:16]));
    $display("test ready done");
    reset_busy = 1'h1;
    status();
    check("in reset", 24'h000001, 24'(st[22]));
    reset_busy = 1'h0;
    status();
    check("out of reset", 24'h000000, 24'(st[22]));
    // reference judged 30 us into a conversion
    pulse(conv_cmd);
    repeat (3000) @(negedge core_clk);
    for (int k = 0; k < 6; k++) begin
      power_state = 2'(k / 2);
      ref_level_ok = k[0];
      status();
      check("reference", 24'(k == 1), 24'(st[14]));
    end
    sv = st;
    host_u.wr(adc_status_pkg::ADDR_STAT, ~sv);
    status();
    check("read only", sv, st);
    $display("test status done");
    results();
  end

  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
